// ===== common/rxpc_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the
  receive-count and pause-control register slice.
  Assumes an APB slave with 32-bit data and a 200 MHz ref_clk.
*/
// Operation
// - Written decrement lowers packet count by one
// - Written zero leaves packet count alone
// - Pause meanings only in full duplex
// - Op 11 sends zero-time pause, clears
// - Op 10 repeats pause frames with timer
// - Op 01 sends one pause, clears
`ifndef RXPC_DEFS_SVH
`define RXPC_DEFS_SVH

`define RXPC_ADDR_W        12
`define RXPC_OFS_CTRL_ONE  12'h000
`define RXPC_OFS_STATUS    12'h004
`define RXPC_OFS_MAC_TWO   12'h008
`define RXPC_OFS_PAUSE_VAL 12'h00c

`define RXPC_BIT_DEC_CMD   8
`define RXPC_FLD_OP_HI     7
`define RXPC_FLD_OP_LO     6
`define RXPC_BIT_FULL_DPX  0

`define RXPC_RST_COUNT     8'h00
`define RXPC_RST_OP        2'h0
`define RXPC_RST_PAUSE     16'h0000
`define RXPC_COUNT_MAX     8'hff

`define RXPC_OP_IDLE       2'h0
`define RXPC_OP_SINGLE     2'h1
`define RXPC_OP_PERIODIC   2'h2
`define RXPC_OP_END        2'h3
`define RXPC_END_TIME      16'h0000

`define RXPC_CLK_PERIOD_PS 5000
`define RXPC_REPEAT_NS     10000
`define RXPC_REPEAT_CYC    ((`RXPC_REPEAT_NS * 1000) / `RXPC_CLK_PERIOD_PS)

`endif

// ===== common/rxpc_pkg.sv
/*
  Types of the receive-count and pause-control register slice.
  Assumes rxpc_defs.svh sits beside it on the include path.
*/
package rxpc_pkg;

  typedef enum logic [1:0] {
    RXPC_IDLE,
    RXPC_SEND,
    RXPC_WAIT
  } rxpc_fsm_e;

  typedef struct packed {
    logic [7:0]  pending_rx_packet_count;
    logic [1:0]  flow_ctrl_operation;
    logic        full_duplex_select;
    logic [15:0] pause_timer_value;
    logic [31:0] prdata;
    rxpc_fsm_e   fsm;
    logic [1:0]  cur_op;
    logic [11:0] wait_cnt;
    logic        pause_req;
    logic [15:0] pause_time;
    logic        backpressure;
  } rxpc_state_s;

  typedef struct packed {
    logic        pause_req;
    logic [15:0] pause_time;
  } rxpc_pause_s;

endpackage

// ===== core/rxpc_ctrl.sv
/*
  APB register slice for the pending receive-packet counter and the
  flow-control (pause / backpressure) command field.
  Assumes the transmitter accepts a pause request with a one-cycle
  pause_ack, and the receiver pulses rx_pkt_done once per stored packet.
*/
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "rxpc_defs.svh"

module rxpc_ctrl (
  input  wire logic                    ref_clk,      // 200 MHz clock
  input  wire logic                    sys_rst,      // Sync reset, high
  input  wire logic                    psel,         // APB select
  input  wire logic                    penable,      // APB access phase
  input  wire logic                    pwrite,       // APB direction
  input  wire logic [`RXPC_ADDR_W-1:0] paddr,        // APB byte address
  input  wire logic [31:0]             pwdata,       // APB write data
  output logic [31:0]                  prdata,       // APB read data
  output logic                         pready,       // APB ready
  output logic                         pslverr,      // Unmapped address
  input  wire logic                    rx_pkt_done,  // One packet stored
  output rxpc_pkg::rxpc_pause_s        pause_out,    // Pause request and time
  input  wire logic                    pause_ack,    // Pause frame sent
  output logic                         backpressure, // Half-duplex preamble
  output logic [7:0]                   pending_rx_packet_count // Count
);

  rxpc_pkg::rxpc_state_s state_reg;
  rxpc_pkg::rxpc_state_s state_next;

  logic        wr_acc;
  logic        rd_setup;
  logic        mapped;
  logic        ctrl_wr;
  logic        dec_cmd;
  logic        op_clear;
  logic [11:0] repeat_load;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign wr_acc      = psel && penable && pwrite;
  assign rd_setup    = psel && !penable && !pwrite;
  assign mapped      = (paddr == `RXPC_OFS_CTRL_ONE) ||
                       (paddr == `RXPC_OFS_STATUS) ||
                       (paddr == `RXPC_OFS_MAC_TWO) ||
                       (paddr == `RXPC_OFS_PAUSE_VAL);
  assign ctrl_wr     = wr_acc && (paddr == `RXPC_OFS_CTRL_ONE);
  assign repeat_load = 12'(`RXPC_REPEAT_CYC - 1);

  // Zero wait states: read data is caught in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_next = state_reg;
    op_clear   = 1'b0;
    dec_cmd = ctrl_wr && pwdata[`RXPC_BIT_DEC_CMD];
    case ({rx_pkt_done, dec_cmd})
      2'b10:
      begin
        if (state_reg.pending_rx_packet_count != `RXPC_COUNT_MAX)
          state_next.pending_rx_packet_count = state_reg.pending_rx_packet_count + 8'h01;
      end
      2'b01:
      begin
        // Saturates so a stray decrement cannot wrap to 255
        if (state_reg.pending_rx_packet_count != `RXPC_RST_COUNT)
          state_next.pending_rx_packet_count = state_reg.pending_rx_packet_count - 8'h01;
      end
      default:
      begin
        state_next.pending_rx_packet_count = state_reg.pending_rx_packet_count;
      end
    endcase

    if (wr_acc && (paddr == `RXPC_OFS_MAC_TWO))
      state_next.full_duplex_select = pwdata[`RXPC_BIT_FULL_DPX];
    if (wr_acc && (paddr == `RXPC_OFS_PAUSE_VAL))
      state_next.pause_timer_value = pwdata[15:0];

    // Pause sequencer
    case (state_reg.fsm)
      rxpc_pkg::RXPC_IDLE:
      begin
        if (state_reg.full_duplex_select &&
            (state_reg.flow_ctrl_operation != `RXPC_OP_IDLE))
        begin
          state_next.cur_op    = state_reg.flow_ctrl_operation;
          state_next.pause_req = 1'b1;
          if (state_reg.flow_ctrl_operation == `RXPC_OP_END)
            state_next.pause_time = `RXPC_END_TIME;
          else
            state_next.pause_time = state_reg.pause_timer_value;
          state_next.fsm = rxpc_pkg::RXPC_SEND;
        end
      end
      rxpc_pkg::RXPC_SEND:
      begin
        // Request held until the transmitter takes it
        if (pause_ack)
        begin
          state_next.pause_req = 1'b0;
          if (state_reg.cur_op == `RXPC_OP_PERIODIC)
          begin
            state_next.wait_cnt = repeat_load;
            state_next.fsm      = rxpc_pkg::RXPC_WAIT;
          end
          else
          begin
            op_clear       = (state_reg.flow_ctrl_operation == state_reg.cur_op);
            state_next.fsm = rxpc_pkg::RXPC_IDLE;
          end
        end
      end
      rxpc_pkg::RXPC_WAIT:
      begin
        if (!state_reg.full_duplex_select ||
            (state_reg.flow_ctrl_operation != `RXPC_OP_PERIODIC))
          state_next.fsm = rxpc_pkg::RXPC_IDLE;
        else if (state_reg.wait_cnt == 12'h000)
        begin
          state_next.pause_req  = 1'b1;
          state_next.pause_time = state_reg.pause_timer_value;
          state_next.fsm        = rxpc_pkg::RXPC_SEND;
        end
        else
          state_next.wait_cnt = state_reg.wait_cnt - 12'h001;
      end
      default:
      begin
        state_next.fsm       = rxpc_pkg::RXPC_IDLE;
        state_next.pause_req = 1'b0;
      end
    endcase

    // Software write wins over the hardware clear in the same cycle
    if (ctrl_wr)
      state_next.flow_ctrl_operation = pwdata[`RXPC_FLD_OP_HI:`RXPC_FLD_OP_LO];
    else if (op_clear)
      state_next.flow_ctrl_operation = `RXPC_OP_IDLE;

    state_next.backpressure = !state_reg.full_duplex_select &&
                              (state_reg.flow_ctrl_operation != `RXPC_OP_IDLE);

    if (rd_setup)
    begin
      case (paddr)
        `RXPC_OFS_CTRL_ONE:
          state_next.prdata = {24'h000000, state_reg.flow_ctrl_operation, 6'h00};
        `RXPC_OFS_STATUS:
          state_next.prdata = {24'h000000, state_reg.pending_rx_packet_count};
        `RXPC_OFS_MAC_TWO:
          state_next.prdata = {31'h00000000, state_reg.full_duplex_select};
        `RXPC_OFS_PAUSE_VAL:
          state_next.prdata = {16'h0000, state_reg.pause_timer_value};
        default:
          state_next.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg.pending_rx_packet_count <= `RXPC_RST_COUNT;
      state_reg.flow_ctrl_operation     <= `RXPC_RST_OP;
      state_reg.full_duplex_select      <= 1'b0;
      state_reg.pause_timer_value       <= `RXPC_RST_PAUSE;
      state_reg.prdata                  <= 32'h00000000;
      state_reg.fsm                     <= rxpc_pkg::RXPC_IDLE;
      state_reg.cur_op                  <= `RXPC_OP_IDLE;
      state_reg.wait_cnt                <= 12'h000;
      state_reg.pause_req               <= 1'b0;
      state_reg.pause_time              <= `RXPC_RST_PAUSE;
      state_reg.backpressure            <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  assign prdata                  = state_reg.prdata;
  assign pause_out               = {state_reg.pause_req, state_reg.pause_time};
  assign backpressure            = state_reg.backpressure;
  assign pending_rx_packet_count = state_reg.pending_rx_packet_count;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  logic no_inc_wr;
  assign no_inc_wr = !rx_pkt_done;

  a_dec_count_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    dec_cmd && no_inc_wr && (state_reg.pending_rx_packet_count != 8'h00)
    |=> state_reg.pending_rx_packet_count ==
        $past(state_reg.pending_rx_packet_count) - 8'h01)
    else $error("count not lowered by one after decrement");

  a_zero_keeps_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_wr && !pwdata[`RXPC_BIT_DEC_CMD] && no_inc_wr
    |=> $stable(state_reg.pending_rx_packet_count))
    else $error("count changed without a decrement");

  // frames start only in full duplex
  a_fdx_frame_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(state_reg.pause_req) |-> $past(state_reg.full_duplex_select))
    else $error("pause frame requested outside full duplex");

  a_end_zero_time: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_reg.pause_req && (state_reg.cur_op == `RXPC_OP_END)
    |-> state_reg.pause_time == `RXPC_END_TIME)
    else $error("end-of-flow pause frame carries nonzero time");

  a_periodic_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg.fsm == rxpc_pkg::RXPC_SEND) && pause_ack &&
    (state_reg.cur_op == `RXPC_OP_PERIODIC)
    |=> (state_reg.fsm == rxpc_pkg::RXPC_WAIT) && !state_reg.pause_req &&
        (state_reg.wait_cnt == repeat_load))
    else $error("periodic pause did not start its interval");

  a_periodic_repeat: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg.fsm == rxpc_pkg::RXPC_WAIT) && (state_reg.wait_cnt == 12'h000) &&
    state_reg.full_duplex_select && (state_reg.flow_ctrl_operation == `RXPC_OP_PERIODIC)
    |=> state_reg.pause_req && (state_reg.pause_time == $past(state_reg.pause_timer_value)))
    else $error("periodic pause frame not repeated");

  a_single_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg.fsm == rxpc_pkg::RXPC_SEND) && pause_ack && !ctrl_wr &&
    (state_reg.cur_op == `RXPC_OP_SINGLE) &&
    (state_reg.flow_ctrl_operation == `RXPC_OP_SINGLE)
    |=> (state_reg.flow_ctrl_operation == `RXPC_OP_IDLE) ##1 !state_reg.pause_req)
    else $error("single pause op not cleared after frame");

  a_half_backpr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 (backpressure == ($past(!state_reg.full_duplex_select) &&
                          ($past(state_reg.flow_ctrl_operation) != 2'h0))))
    else $error("backpressure does not follow duplex and op");

  a_inc_dec_cancel: assert property (@(posedge ref_clk) disable iff (sys_rst)
    dec_cmd && rx_pkt_done
    |=> $stable(state_reg.pending_rx_packet_count))
    else $error("count moved when store and decrement met");

  a_dec_reads_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_setup && (paddr == `RXPC_OFS_CTRL_ONE)
    |=> !state_reg.prdata[`RXPC_BIT_DEC_CMD])
    else $error("decrement bit read back as one");

  a_half_no_frame: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !state_reg.full_duplex_select && (state_reg.fsm == rxpc_pkg::RXPC_IDLE)
    |=> !state_reg.pause_req)
    else $error("pause frame launched in half duplex");

  a_fdx_no_backpr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_reg.full_duplex_select
    |=> !backpressure)
    else $error("backpressure asserted in full duplex");

  a_end_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg.fsm == rxpc_pkg::RXPC_SEND) && pause_ack && !ctrl_wr &&
    (state_reg.cur_op == `RXPC_OP_END) && (state_reg.flow_ctrl_operation == `RXPC_OP_END)
    |=> state_reg.flow_ctrl_operation == `RXPC_OP_IDLE)
    else $error("end-of-flow op not cleared after frame");

  a_req_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_reg.pause_req && !pause_ack
    |=> state_reg.pause_req && $stable(state_reg.pause_time))
    else $error("pause request dropped before acknowledge");

  a_wait_aborts: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg.fsm == rxpc_pkg::RXPC_WAIT) &&
    (!state_reg.full_duplex_select || (state_reg.flow_ctrl_operation != `RXPC_OP_PERIODIC))
    |=> (state_reg.fsm == rxpc_pkg::RXPC_IDLE) && !state_reg.pause_req)
    else $error("periodic interval kept running after op change");

  c_decrement: cover property (@(posedge ref_clk) disable iff (sys_rst)
    dec_cmd && (state_reg.pending_rx_packet_count != 8'h00));
  c_periodic_twice: cover property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg.fsm == rxpc_pkg::RXPC_WAIT) ##1 $rose(state_reg.pause_req));
  c_end_frame: cover property (@(posedge ref_clk) disable iff (sys_rst)
    pause_ack && (state_reg.cur_op == `RXPC_OP_END));
  c_backpressure: cover property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(backpressure));
  c_inc_dec: cover property (@(posedge ref_clk) disable iff (sys_rst)
    dec_cmd && rx_pkt_done);

endmodule

// ===== testbench/rxpc_tb.sv
/*
  Self-checking bench of the receive-count and pause-control slice.
  Assumes rxpc_pkg is compiled first and rxpc_defs.svh is on the include path.
*/
`timescale 1ns/1ps
`include "rxpc_defs.svh"

module testbench;
  logic                    ref_clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [`RXPC_ADDR_W-1:0] paddr = 12'h000;
  logic [31:0]             pwdata = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    rx_pkt_done = 1'b0;
  rxpc_pkg::rxpc_pause_s   pause_out;
  logic                    pause_ack = 1'b0;
  logic                    backpressure;
  logic [7:0]              cnt;
  logic [32:0]             exp_q[$];
  logic [31:0]             rnd = 32'ha780;
  logic [15:0]             tmr;
  logic [7:0]              n;
  int                      n_mismatch = 0;
  int                      samples_checked = 0;
  int                      cyc = 0;
  int                      gap;

  rxpc_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pkt_done(rx_pkt_done), .pause_out(pause_out),
    .pause_ack(pause_ack), .backpressure(backpressure), .pending_rx_packet_count(cnt));

  always #2.5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Leading idle edge keeps a driver from assigning twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_req(output int c);
    c = 0;
    @(posedge ref_clk);
    while (pause_out.pause_req !== 1'b1 && c < 3000)
    begin
      @(posedge ref_clk);
      c++;
    end
  endtask

  task automatic ack;
    @(posedge ref_clk) pause_ack <= 1'b1;
    @(posedge ref_clk) pause_ack <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read answers compared against the oldest note
  always @(posedge ref_clk)
  begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_mismatch++;
      stop_test;
    end
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`RXPC_OFS_CTRL_ONE, 33'h0);
    rd(`RXPC_OFS_STATUS, 33'h0);
    rd(`RXPC_OFS_MAC_TWO, 33'h0);
    rd(`RXPC_OFS_PAUSE_VAL, 33'h0);
    rnd = lfsr(rnd);
    n = 8'h03 + {6'h0, rnd[1:0]};
    repeat (n)
    begin
      @(posedge ref_clk) rx_pkt_done <= 1'b1;
      @(posedge ref_clk) rx_pkt_done <= 1'b0;
    end
    apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'h0);
    rd(`RXPC_OFS_STATUS, {25'h0, n});
    apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'h100);
    apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'h100);
    // Store and decrement in one access cycle cancel out
    fork
      apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'h100);
      begin
        repeat (2) @(posedge ref_clk);
        rx_pkt_done <= 1'b1;
        @(posedge ref_clk);
        rx_pkt_done <= 1'b0;
      end
    join
    rd(`RXPC_OFS_STATUS, {25'h0, n - 8'h02});
    rd(`RXPC_OFS_CTRL_ONE, 33'h0);
    chk({25'h0, cnt}, {25'h0, n - 8'h02});
    rnd = lfsr(rnd);
    tmr = rnd[15:0];
    apb(1'b1, `RXPC_OFS_PAUSE_VAL, {16'h0, tmr});
    rd(`RXPC_OFS_PAUSE_VAL, {17'h0, tmr});
    apb(1'b1, `RXPC_OFS_MAC_TWO, 32'h1);
    // Single and ending pause frames clear the field after the ack
    for (int op = 1; op < 4; op += 2)
    begin
      apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'(op) << 6);
      wait_req(gap);
      repeat (3) @(posedge ref_clk);
      chk({16'h0, pause_out}, {17'h1, (op == 3) ? 16'h0 : tmr});
      ack;
      repeat (2) @(posedge ref_clk);
      chk({32'h0, pause_out.pause_req}, 33'h0);
      rd(`RXPC_OFS_CTRL_ONE, 33'h0);
    end
    apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'h80);
    wait_req(gap);
    ack;
    wait_req(gap);
    chk({32'h0, gap >= `RXPC_REPEAT_CYC}, 33'h1);
    chk({16'h0, pause_out}, {17'h1, tmr});
    ack;
    rd(`RXPC_OFS_CTRL_ONE, 33'h80);
    apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'h0);
    // Half duplex: every nonzero code holds preamble, no pause frames
    apb(1'b1, `RXPC_OFS_MAC_TWO, 32'h0);
    for (int op = 1; op < 4; op++)
    begin
      apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'(op) << 6);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, backpressure, pause_out.pause_req}, 33'h2);
    end
    apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, backpressure, pause_out.pause_req}, 33'h0);
    apb(1'b1, 12'h010, 32'hffffffff);
    rd(12'h010, {1'b1, 32'h0});
    rd(`RXPC_OFS_STATUS, {25'h0, n - 8'h02});
    // Reset in mid-frame drops the request and every field
    apb(1'b1, `RXPC_OFS_MAC_TWO, 32'h1);
    apb(1'b1, `RXPC_OFS_CTRL_ONE, 32'h80);
    wait_req(gap);
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk({31'h0, backpressure, pause_out.pause_req}, 33'h0);
    rd(`RXPC_OFS_CTRL_ONE, 33'h0);
    rd(`RXPC_OFS_STATUS, 33'h0);
    rd(`RXPC_OFS_MAC_TWO, 33'h0);
    rd(`RXPC_OFS_PAUSE_VAL, 33'h0);
    repeat (3) @(posedge ref_clk);
    chk({32'h0, exp_q.size() == 0}, 33'h1);
    stop_test;
  end
endmodule
